// ===== design/cpx_exec_core.sv
// Purpose: executes copy, literal, option, return, rotate and idle ops
// Assumes: one instruction per Wishbone write to the instruction word
// Notes:   returns hold busy for one extra cycle; instruction writes while busy drop
//
// Contract
// - copy file to working or back to file
// - copy file updates zero flag from value
// - bank literal loads bank select, flags kept
// - working literal loads working, flags kept
// - option load copies working, flags kept
// - interrupt return pops pc, sets irq enable
// - interrupt return takes two cycles
// - literal return loads working, pops, two cycles
// - plain return pops pc, two cycles
module cpx_exec_core
  import cpx_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // core state towards neighbours
  output logic      [7:0]  optionOut,
  output logic      [2:0]  bankSelOut,
  output logic             globalIrqEnableOut
);
  logic [7:0]      workReg_r;
  logic            zeroFlag_r;
  logic            carryFlag_r;
  logic [PC_W-1:0] pc_r;
  logic [7:0]      fileMem [32];
  cpx_state_t      state_r;

  // bus strobes: writes land on the ack edge
  logic acc;
  logic wrStb;
  logic fileSel;
  assign acc     = wb_cyc_i & wb_stb_i;
  assign wrStb   = acc & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign fileSel = wb_adr_i[7];

  // instruction issue and decode
  logic [11:0]        instr;
  logic               issue;
  logic [FADDR_W-1:0] fAddr;
  logic               dest;
  logic [7:0]         fileRd;
  logic               isCopy, isRot, isBank, isWork, isOpt;
  logic               isRet, isIrqRet, isRetLit, isIdle, isReturn;
  assign instr    = wb_dat_i[INSTR_W-1:0];
  assign issue    = wrStb & ~fileSel & (wb_adr_i == OFF_INSTR) & (state_r == CPX_RUN);
  assign fAddr    = instr[FADDR_W-1:0];
  assign dest     = instr[DEST_BIT];
  assign fileRd   = fileMem[fAddr];
  assign isCopy   = instr[11:6] == OPC_COPY_FILE;
  assign isRot    = instr[11:6] == OPC_ROT_LEFT;
  assign isBank   = instr[11:3] == OPC_BANK_LIT;
  assign isWork   = instr[11:8] == OPC_WORK_LIT;
  assign isRetLit = instr[11:8] == OPC_RET_LIT;
  assign isOpt    = instr == OPC_OPTION;
  assign isIrqRet = instr == OPC_IRQ_RET;
  assign isReturn = instr == OPC_RETURN;
  assign isIdle   = instr == OPC_IDLE;
  assign isRet    = isIrqRet | isRetLit | isReturn;

  // result of the file-sourced ops
  logic [7:0] fileRes;
  logic       wrFileOp;
  assign fileRes  = isRot ? {fileRd[6:0], carryFlag_r} : fileRd;
  assign wrFileOp = issue & (isCopy | isRot) & dest;

  logic [PC_W-1:0] stackTop;
  logic            stackPush;
  assign stackPush = wrStb & ~fileSel & (wb_adr_i == OFF_PUSH);

  cpx_ret_stack u_stack (
    .clk     (clk),
    .rst     (rst),
    .push    (stackPush),
    .pushVal (wb_dat_i[PC_W-1:0]),
    .pop     (issue & isRet),
    .top     (stackTop)
  );

  // bus answer, one wait state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (acc & ~wb_ack_o) begin
      if (fileSel) begin
        wb_dat_o <= {24'h0, fileMem[wb_adr_i[6:2]]};
      end else begin
        unique case (wb_adr_i)
          OFF_WORK:   wb_dat_o <= {24'h0, workReg_r};
          OFF_STATUS: wb_dat_o <= {25'h0, state_r == CPX_SECND, globalIrqEnableOut,
                                   bankSelOut, carryFlag_r, zeroFlag_r};
          OFF_OPTION: wb_dat_o <= {24'h0, optionOut};
          OFF_PC:     wb_dat_o <= {21'h0, pc_r};
          OFF_PUSH:   wb_dat_o <= {21'h0, stackTop};
          default:    wb_dat_o <= '0;
        endcase
      end
    end
  end

  // two-cycle ops park here for the flushed slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= CPX_RUN;
    end else begin
      unique case (state_r)
        CPX_RUN:   state_r <= (issue & isRet) ? CPX_SECND : CPX_RUN;
        CPX_SECND: state_r <= CPX_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_r <= RST_PC;
    end else if (issue & isRet) begin
      pc_r <= stackTop;
    end else if (issue) begin
      pc_r <= pc_r + 11'd1;
    end else if (wrStb & ~fileSel & (wb_adr_i == OFF_PC)) begin
      pc_r <= wb_dat_i[PC_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      workReg_r <= RST_WORK;
    end else if (issue & (isCopy | isRot) & ~dest) begin
      workReg_r <= fileRes;
    end else if (issue & (isWork | isRetLit)) begin
      workReg_r <= instr[7:0];
    end else if (wrStb & ~fileSel & (wb_adr_i == OFF_WORK)) begin
      workReg_r <= wb_dat_i[7:0];
    end
  end

  // file writes: instruction wins over a bus write in the same slot
  always_ff @(posedge clk) begin
    if (wrFileOp) begin
      fileMem[fAddr] <= fileRes;
    end else if (wrStb & fileSel) begin
      fileMem[wb_adr_i[6:2]] <= wb_dat_i[7:0];
    end
  end

  logic stWr;
  assign stWr = wrStb & ~fileSel & (wb_adr_i == OFF_STATUS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zeroFlag_r  <= 1'b0;
      carryFlag_r <= 1'b0;
    end else if (issue & isCopy) begin
      zeroFlag_r <= fileRd == 8'h00;
    end else if (issue & isRot) begin
      carryFlag_r <= fileRd[7];
    end else if (stWr) begin
      zeroFlag_r  <= wb_dat_i[ST_Z];
      carryFlag_r <= wb_dat_i[ST_C];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bankSelOut <= RST_BSR;
    end else if (issue & isBank) begin
      bankSelOut <= instr[2:0];
    end else if (stWr) begin
      bankSelOut <= wb_dat_i[ST_BSR+:3];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      globalIrqEnableOut <= 1'b0;
    end else if (issue & isIrqRet) begin
      globalIrqEnableOut <= 1'b1;
    end else if (stWr) begin
      globalIrqEnableOut <= wb_dat_i[ST_GIE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      optionOut <= RST_OPTION;
    end else if (issue & isOpt) begin
      optionOut <= workReg_r;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_retIssue;
    issue && isRet;
  endsequence
  sequence s_twoCycle;
    state_r == CPX_SECND ##1 state_r == CPX_RUN;
  endsequence

  property p_copyDest;
    issue && isCopy |=> (($past(dest) == 1'b0) ? workReg_r == $past(fileRd)
                                  : fileMem[$past(fAddr)] == $past(fileRd));
  endproperty
  a_copyDest: assert property (p_copyDest) else $error("copy lost value");

  property p_copyZero;
    issue && isCopy |=> zeroFlag_r == ($past(fileRd) == 8'h00) && carryFlag_r == $past(carryFlag_r);
  endproperty
  a_copyZero: assert property (p_copyZero) else $error("copy zero flag wrong");

  property p_bankLit;
    issue && isBank |=> bankSelOut == $past(instr[2:0]) && $stable(zeroFlag_r) && $stable(carryFlag_r);
  endproperty
  a_bankLit: assert property (p_bankLit) else $error("bank literal wrong");

  property p_workLit;
    issue && isWork |=> workReg_r == $past(instr[7:0]) && $stable(zeroFlag_r) && $stable(carryFlag_r);
  endproperty
  a_workLit: assert property (p_workLit) else $error("working literal wrong");

  property p_optLoad;
    issue && isOpt |=> optionOut == $past(workReg_r) && $stable(zeroFlag_r) &&
      $stable(carryFlag_r);
  endproperty
  a_optLoad: assert property (p_optLoad) else $error("option load wrong");

  property p_irqRet;
    issue && isIrqRet |=> pc_r == $past(stackTop) && globalIrqEnableOut;
  endproperty
  a_irqRet: assert property (p_irqRet) else $error("interrupt return wrong");

  property p_twoCycle;
    s_retIssue |=> s_twoCycle;
  endproperty
  a_twoCycle: assert property (p_twoCycle) else $error("return not two cycles");

  property p_retLit;
    issue && isRetLit |=> workReg_r == $past(instr[7:0]) && pc_r == $past(stackTop);
  endproperty
  a_retLit: assert property (p_retLit) else $error("literal return wrong");

  property p_plainRet;
    issue && isReturn |=> pc_r == $past(stackTop) && $stable(zeroFlag_r) && $stable(carryFlag_r);
  endproperty
  a_plainRet: assert property (p_plainRet) else $error("plain return wrong");

  property p_rotLeft;
    issue && isRot |=> carryFlag_r == $past(fileRd[7]) &&
      (($past(dest) == 1'b0) ? workReg_r == {$past(fileRd[6:0]), $past(carryFlag_r)}
                             : fileMem[$past(fAddr)] == {$past(fileRd[6:0]), $past(carryFlag_r)});
  endproperty
  a_rotLeft: assert property (p_rotLeft) else $error("rotate left wrong");

  property p_idle;
    issue && isIdle |=> pc_r == $past(pc_r) + 11'd1 && $stable(workReg_r) &&
      $stable(zeroFlag_r) && $stable(carryFlag_r) && state_r == CPX_RUN;
  endproperty
  a_idle: assert property (p_idle) else $error("idle op changed state");
endmodule

// ===== design/cpx_pkg.sv
// Purpose: shared constants for the move/return execution core
// Assumes: 12-bit instruction words, 32-bit classic Wishbone register port
// Notes:   offsets are byte addresses, one aligned word each
package cpx_pkg;
  // widths
  localparam int unsigned INSTR_W   = 12;
  localparam int unsigned PC_W      = 11;
  localparam int unsigned FADDR_W   = 5;
  localparam int unsigned STACK_DEP = 4;
  localparam int unsigned SPTR_W    = 2;

  // register offsets
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_WORK   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_OPTION = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_PUSH   = 8'h14;
  // file registers at OFF_FILE + 4*f
  localparam logic [7:0] OFF_FILE   = 8'h80;

  // status word fields
  localparam int unsigned ST_Z    = 0;
  localparam int unsigned ST_C    = 1;
  localparam int unsigned ST_BSR  = 2;
  localparam int unsigned ST_GIE  = 5;
  localparam int unsigned ST_BUSY = 6;

  // reset values
  localparam logic [7:0]      RST_WORK   = 8'h00;
  localparam logic [7:0]      RST_OPTION = 8'hff;
  localparam logic [2:0]      RST_BSR    = 3'h0;
  localparam logic [PC_W-1:0] RST_PC     = 11'h000;

  // opcode patterns
  localparam logic [11:0] OPC_IDLE      = 12'h000;
  localparam logic [11:0] OPC_OPTION    = 12'h002;
  localparam logic [11:0] OPC_RETURN    = 12'h01e;
  localparam logic [11:0] OPC_IRQ_RET   = 12'h01f;
  localparam logic [8:0]  OPC_BANK_LIT  = 9'h002;
  localparam logic [5:0]  OPC_COPY_FILE = 6'h08;
  localparam logic [5:0]  OPC_ROT_LEFT  = 6'h0d;
  localparam logic [3:0]  OPC_RET_LIT   = 4'h8;
  localparam logic [3:0]  OPC_WORK_LIT  = 4'hc;
  localparam int unsigned DEST_BIT      = 5;

  typedef enum logic [0:0] {
    CPX_RUN   = 1'b0,
    CPX_SECND = 1'b1
  } cpx_state_t;
endpackage

// ===== design/cpx_ret_stack.sv
// Purpose: return-address stack, four entries, wraps on over/underflow
// Assumes: push and pop never in the same cycle
// Notes:   no empty or full flag; software must track its own depth
module cpx_ret_stack
  import cpx_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // control
  input  wire logic            push,
  input  wire logic [PC_W-1:0] pushVal,
  input  wire logic            pop,
  // view
  output logic      [PC_W-1:0] top
);
  logic [PC_W-1:0]   mem [STACK_DEP];
  logic [SPTR_W-1:0] ptr_r;

  assign top = mem[ptr_r - 2'd1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_r <= '0;
    end else if (push) begin
      ptr_r <= ptr_r + 2'd1;
    end else if (pop) begin
      ptr_r <= ptr_r - 2'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STACK_DEP; i++) begin
        mem[i] <= '0;
      end
    end else if (push) begin
      mem[ptr_r] <= pushVal;
    end
  end
endmodule

// ===== test/test_baseline_cpu_move_return_ops.sv
// Purpose: self-checking bench for the move/return execution core
// Assumes: one wait state per bus access, ops act at their ack edge
// Notes:   the one-cycle busy window is too short to see over the bus
module test_baseline_cpu_move_return_ops
  import cpx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // clock and reset
  logic        clk;
  logic        rst;
  // wishbone master side
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic        wbAck;
  // core outputs
  logic [7:0]  optionOut;
  logic [2:0]  bankSelOut;
  logic        globalIrqEnableOut;
  // bookkeeping
  int          n_errors;
  int          total_checks;
  int          cycles;

  cpx_exec_core dut (
    .clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .optionOut(optionOut), .bankSelOut(bankSelOut),
    .globalIrqEnableOut(globalIrqEnableOut)
  );

  always #25 clk = ~clk;

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; read data taken at the ack edge only
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbDatW <= d;
    wbSel  <= s;
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbx(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wbx(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask

  task automatic op(input logic [11:0] x);
    wr(OFF_INSTR, {20'h0, x});
    @(negedge clk);
  endtask

  function automatic logic [7:0] fa(input int f);
    return 8'(OFF_FILE + 4 * f);
  endfunction

  task automatic t_reset();
    rchk("status", OFF_STATUS, 32'h0);
    rchk("work", OFF_WORK, 32'h0);
    rchk("option", OFF_OPTION, 32'hff);
    chk("optionOut", 32'hff, {24'h0, optionOut});
    chk("bankSel", 32'h0, {29'h0, bankSelOut});
    chk("gie", 32'h0, {31'h0, globalIrqEnableOut});
  endtask

  task automatic t_copy();
    wr(OFF_WORK, 32'h55);
    wr(fa(31), 32'h00);
    wr(OFF_STATUS, 32'h2);
    op({OPC_COPY_FILE, 1'b1, 5'd31});
    rchk("status", OFF_STATUS, 32'h3);
    rchk("file31", fa(31), 32'h0);
    rchk("work", OFF_WORK, 32'h55);
    wr(fa(4), 32'ha5);
    op({OPC_COPY_FILE, 1'b0, 5'd4});
    rchk("work", OFF_WORK, 32'ha5);
    rchk("status", OFF_STATUS, 32'h2);
  endtask

  task automatic t_bank();
    wr(OFF_STATUS, 32'h3);
    for (int k = 0; k < 8; k++) begin
      op({OPC_BANK_LIT, 3'(k)});
      chk("bankSel", 32'(k), {29'h0, bankSelOut});
      rchk("status", OFF_STATUS, 32'((k << 2) | 3));
    end
  endtask

  task automatic t_work();
    op({OPC_WORK_LIT, 8'hff});
    rchk("work", OFF_WORK, 32'hff);
    op({OPC_WORK_LIT, 8'h00});
    rchk("work", OFF_WORK, 32'h0);
    rchk("status", OFF_STATUS, 32'h1f);
  endtask

  task automatic t_option();
    wr(OFF_WORK, 32'h3c);
    op(OPC_OPTION);
    chk("optionOut", 32'h3c, {24'h0, optionOut});
    rchk("option", OFF_OPTION, 32'h3c);
    rchk("status", OFF_STATUS, 32'h1f);
  endtask

  task automatic t_returns();
    wr(OFF_STATUS, 32'h0);
    wr(OFF_PUSH, 32'h123);
    wr(OFF_PUSH, 32'h456);
    wr(OFF_PUSH, 32'h7ff);
    op(OPC_IRQ_RET);
    chk("gie", 32'h1, {31'h0, globalIrqEnableOut});
    rchk("pc", OFF_PC, 32'h7ff);
    rchk("status", OFF_STATUS, 32'h20);
    op({OPC_RET_LIT, 8'h9a});
    rchk("work", OFF_WORK, 32'h9a);
    rchk("pc", OFF_PC, 32'h456);
    op(OPC_RETURN);
    rchk("pc", OFF_PC, 32'h123);
    rchk("status", OFF_STATUS, 32'h20);
  endtask

  task automatic t_rotate();
    wr(OFF_STATUS, 32'h1);
    wr(fa(7), 32'h81);
    op({OPC_ROT_LEFT, 1'b1, 5'd7});
    rchk("file7", fa(7), 32'h02);
    rchk("status", OFF_STATUS, 32'h3);
    op({OPC_ROT_LEFT, 1'b0, 5'd7});
    rchk("work", OFF_WORK, 32'h05);
    rchk("file7", fa(7), 32'h02);
    rchk("status", OFF_STATUS, 32'h1);
  endtask

  task automatic t_idle();
    wr(OFF_PC, 32'h2a);
    wr(OFF_PUSH, 32'h321);
    op(OPC_IDLE);
    rchk("pc", OFF_PC, 32'h2b);
    rchk("work", OFF_WORK, 32'h05);
    rchk("status", OFF_STATUS, 32'h1);
    rchk("stack", OFF_PUSH, 32'h321);
  endtask

  // unmapped place, write-only word and a write with sel[0] low
  task automatic t_bus();
    logic [31:0] q;
    rchk("unmapped", 8'h40, 32'h0);
    rchk("instr", OFF_INSTR, 32'h0);
    wbx(1'b1, OFF_WORK, 32'h77, 4'he, q);
    rchk("work", OFF_WORK, 32'h05);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_copy();
    t_bank();
    t_work();
    t_option();
    t_returns();
    t_rotate();
    t_idle();
    t_bus();
    results();
  end
endmodule
